// ==== rtl/tpe_error_count.sv ====
// Error counter, threshold compare and interrupt of the transmit
// pattern checker. Error pulses and period-end strobes come from logic
// on ref_clk; software uses the byte register port.
//
// Overview of operation
// R1 - Interrupt when count exceeds decoded threshold
// R2 - Threshold byte is mantissa/16 times 16^exponent
// R3 - Compare absolute count, never a rate
// R4 - Finite period: show last completed period total
// R5 - Continuous period: show live running total
// R6 - Low byte read snapshots four upper bytes
// R7 - Count is 40 bits over five bytes
// R8 - Threshold resets to all ones
// R9 - Count also readable as one-byte float
// R10 - Count saturates; compare on every count change
`timescale 1ns/100ps
`default_nettype none
module tpe_error_count (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [tpe_pkg::TPE_ADDR_W-1:0] regAddr,
  input wire logic [tpe_pkg::TPE_DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [tpe_pkg::TPE_DATA_W-1:0] regRdData,
  // Checker events
  input wire logic errPulse,
  input wire logic periodEnd,
  // Interrupt
  output logic irq
);
  import tpe_pkg::*;

  // Software state
  logic [7:0] threshold_reg;
  logic [1:0] periodSel_reg;
  logic [TPE_ST_W-1:0] status_reg;
  logic [TPE_ST_W-1:0] status_next;
  logic [TPE_ST_W-1:0] mask_reg;
  logic [31:0] snapUpper_reg;

  // Counting state
  logic [TPE_COUNT_W-1:0] accum_reg;
  logic [TPE_COUNT_W-1:0] accum_next;
  logic [TPE_COUNT_W-1:0] report_reg;
  logic [TPE_COUNT_W-1:0] report_next;
  logic [TPE_COUNT_W-1:0] accumInc;
  logic accumAtMax;
  logic [TPE_COUNT_W-1:0] reportInc;
  logic reportAtMax;

  // Decode and compare
  logic [TPE_DEC_W-1:0] thrDecoded;
  logic [TPE_FIELD_W-1:0] thrMant;
  logic [TPE_FIELD_W-1:0] thrExp;
  logic aboveNew;
  logic aboveOld;
  logic countChanged;
  logic evAbove;
  logic evPeriod;
  logic evSat;

  // Strobes decoded from the register port
  logic wrThreshold;
  logic wrControl;
  logic wrStatus;
  logic wrMask;
  logic rdCount0;
  logic clearReq;
  logic periodActive;
  logic isContinuous;
  logic [7:0] countFloat;
  logic [7:0] rdMux;

  assign wrThreshold = regWrStb && (regAddr == TPE_OFF_THRESHOLD);
  assign wrControl = regWrStb && (regAddr == TPE_OFF_CONTROL);
  assign wrStatus = regWrStb && (regAddr == TPE_OFF_STATUS);
  assign wrMask = regWrStb && (regAddr == TPE_OFF_MASK);
  assign rdCount0 = regRdStb && (regAddr == TPE_OFF_COUNT0);
  assign clearReq = wrControl && regWrData[TPE_CTL_CLEAR_BIT];

  assign isContinuous = (periodSel_reg == TPE_PERIOD_CONT);
  assign periodActive = periodEnd && !isContinuous;

  // Threshold register, all ones after reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      threshold_reg <= TPE_RST_THRESHOLD; // R8
    end else if (wrThreshold) begin
      threshold_reg <= regWrData;
    end
  end

  // Period select
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      periodSel_reg <= TPE_RST_PERIOD;
    end else if (wrControl) begin
      periodSel_reg <= regWrData[TPE_CTL_PERIOD_LSB +: 2];
    end
  end

  // Interrupt mask
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask_reg <= TPE_RST_MASK;
    end else if (wrMask) begin
      mask_reg <= regWrData[TPE_ST_W-1:0];
    end
  end

  // Saturating increments of both accumulators
  tpe_sat_add #(
    .W(TPE_COUNT_W)
  ) u_accumInc (
    .valueIn(accum_reg),
    .inc(errPulse),
    .valueOut(accumInc),
    .atMax(accumAtMax)
  ); // R10

  tpe_sat_add #(
    .W(TPE_COUNT_W)
  ) u_reportInc (
    .valueIn(report_reg),
    .inc(errPulse),
    .valueOut(reportInc),
    .atMax(reportAtMax)
  );

  // Running total for the current period
  always_comb begin
    accum_next = accumInc;
    if (clearReq) begin
      accum_next = '0;
    end else if (periodActive) begin
      // Error in the boundary cycle belongs to the closing period
      accum_next = '0; // R4
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      accum_reg <= '0;
    end else begin
      accum_reg <= accum_next;
    end
  end

  // Reported total: live or captured at period ends
  always_comb begin
    report_next = report_reg;
    if (clearReq) begin
      report_next = '0;
    end else if (isContinuous) begin
      report_next = reportInc; // R5
    end else if (periodEnd) begin
      report_next = accumInc; // R4
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      report_reg <= '0;
    end else begin
      report_reg <= report_next; // R7
    end
  end

  // Threshold decode: value is mantissa shifted by 4*(exp-1)
  assign thrMant = threshold_reg[TPE_MANT_LSB +: TPE_FIELD_W];
  assign thrExp = threshold_reg[TPE_EXP_LSB +: TPE_FIELD_W];

  always_comb begin
    thrDecoded = '0;
    // Exponent zero gives a fraction below one, so its floor is zero
    if (thrExp != 4'h0) begin
      thrDecoded = TPE_DEC_W'(thrMant) << (6'(thrExp - 4'h1) << 2); // R2
    end
  end

  // Absolute count compare, old and new values
  assign aboveNew = TPE_DEC_W'(report_next) > thrDecoded; // R3
  assign aboveOld = TPE_DEC_W'(report_reg) > thrDecoded;
  assign countChanged = report_next != report_reg;
  assign evAbove = countChanged && aboveNew && !aboveOld; // R1 R10
  assign evPeriod = periodActive;
  assign evSat = (errPulse && (isContinuous ? reportAtMax : accumAtMax));

  // Sticky status, write one to clear, set wins
  always_comb begin
    status_next = status_reg;
    if (wrStatus) begin
      status_next = status_reg & ~regWrData[TPE_ST_W-1:0];
    end
    if (evAbove) begin
      status_next[TPE_ST_ABOVE] = 1'b1; // R1
    end
    if (evPeriod) begin
      status_next[TPE_ST_PERIOD] = 1'b1;
    end
    if (evSat) begin
      status_next[TPE_ST_SAT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  // Level interrupt from registered status and mask
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg); // R1
    end
  end

  // Upper bytes frozen when the low byte is read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      snapUpper_reg <= '0;
    end else if (rdCount0) begin
      snapUpper_reg <= report_reg[TPE_COUNT_W-1:8]; // R6
    end
  end

  // Same count in one-byte float form
  tpe_float_enc #(
    .W(TPE_COUNT_W)
  ) u_floatEnc (
    .countIn(report_reg),
    .floatOut(countFloat)
  ); // R9

  // Read multiplexer
  always_comb begin
    rdMux = TPE_RD_UNMAPPED;
    case (regAddr)
      TPE_OFF_THRESHOLD: begin
        rdMux = threshold_reg;
      end
      TPE_OFF_COUNT0: begin
        rdMux = report_reg[7:0]; // R6
      end
      TPE_OFF_COUNT1: begin
        rdMux = snapUpper_reg[7:0]; // R7
      end
      TPE_OFF_COUNT2: begin
        rdMux = snapUpper_reg[15:8];
      end
      TPE_OFF_COUNT3: begin
        rdMux = snapUpper_reg[23:16];
      end
      TPE_OFF_COUNT4: begin
        rdMux = snapUpper_reg[31:24];
      end
      TPE_OFF_FLOAT: begin
        rdMux = countFloat; // R9
      end
      TPE_OFF_CONTROL: begin
        rdMux = {6'h00, periodSel_reg};
      end
      TPE_OFF_STATUS: begin
        rdMux = {5'h00, status_reg};
      end
      TPE_OFF_MASK: begin
        rdMux = {5'h00, mask_reg};
      end
      default: begin
        rdMux = TPE_RD_UNMAPPED;
      end
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdData <= '0;
    end else if (regRdStb) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= '0;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/tpe_float_enc.sv ====
// Compresses a count into the one-byte base-16 float format.
// Purely combinational; mantissa is the top nonzero nibble, truncated.
`timescale 1ns/100ps
`default_nettype none
module tpe_float_enc #(
  parameter int W = 40
) (
  // Count in
  input wire logic [W-1:0] countIn,
  // Float out
  output logic [7:0] floatOut
);

  localparam int NIB = W / 4;

  always_comb begin
    floatOut = 8'h00;
    for (int i = 0; i < NIB; i++) begin
      if (countIn[4*i +: 4] != 4'h0) begin
        floatOut = {countIn[4*i +: 4], 4'(i + 1)};
      end
    end
  end

endmodule
`default_nettype wire

// ==== rtl/tpe_pkg.sv ====
// Constants for the transmit pattern checker error counter.
// Assumes an 8-bit register port with byte-wide offsets.
`default_nettype none
package tpe_pkg;

  // Register offsets
  localparam logic [7:0] TPE_OFF_THRESHOLD = 8'hAF;
  localparam logic [7:0] TPE_OFF_COUNT0 = 8'hB0;
  localparam logic [7:0] TPE_OFF_COUNT1 = 8'hB1;
  localparam logic [7:0] TPE_OFF_COUNT2 = 8'hB2;
  localparam logic [7:0] TPE_OFF_COUNT3 = 8'hB3;
  localparam logic [7:0] TPE_OFF_COUNT4 = 8'hB4;
  localparam logic [7:0] TPE_OFF_FLOAT = 8'hB5;
  localparam logic [7:0] TPE_OFF_CONTROL = 8'hC0;
  localparam logic [7:0] TPE_OFF_STATUS = 8'hC1;
  localparam logic [7:0] TPE_OFF_MASK = 8'hC2;

  // Widths
  localparam int TPE_ADDR_W = 8;
  localparam int TPE_DATA_W = 8;
  localparam int TPE_COUNT_W = 40;
  localparam int TPE_DEC_W = 64;

  // Float field positions
  localparam int TPE_MANT_LSB = 4;
  localparam int TPE_EXP_LSB = 0;
  localparam int TPE_FIELD_W = 4;

  // Control field positions
  localparam int TPE_CTL_PERIOD_LSB = 0;
  localparam int TPE_CTL_CLEAR_BIT = 7;

  // Status and mask bit positions
  localparam int TPE_ST_ABOVE = 0;
  localparam int TPE_ST_PERIOD = 1;
  localparam int TPE_ST_SAT = 2;
  localparam int TPE_ST_W = 3;

  // Reset values
  localparam logic [7:0] TPE_RST_THRESHOLD = 8'hFF;
  localparam logic [1:0] TPE_RST_PERIOD = 2'h0;
  localparam logic [2:0] TPE_RST_MASK = 3'h0;
  localparam logic [7:0] TPE_RD_UNMAPPED = 8'h00;

  // Measurement period select codes
  typedef enum logic [1:0] {
    TPE_PERIOD_A = 2'b00,
    TPE_PERIOD_B = 2'b01,
    TPE_PERIOD_C = 2'b10,
    TPE_PERIOD_CONT = 2'b11
  } tpe_period_t;

endpackage
`default_nettype wire

// ==== rtl/tpe_sat_add.sv ====
// Saturating incrementer for the error accumulators.
// Purely combinational; used by the count logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module tpe_sat_add #(
  parameter int W = 40
) (
  // Operand
  input wire logic [W-1:0] valueIn,
  input wire logic inc,
  // Result
  output logic [W-1:0] valueOut,
  output logic atMax
);

  assign atMax = &valueIn;
  // Hold at the top instead of wrapping
  assign valueOut = (inc && !atMax) ? valueIn + W'(1) : valueIn;

endmodule
`default_nettype wire

// ==== test/tpe_error_count_asserts.sv ====
// Port-level checker for the error counter block.
// Bound to tpe_error_count from the bench top; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module tpe_error_count_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [7:0] regRdData,
  // Events and interrupt
  input wire logic errPulse,
  input wire logic periodEnd,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic quiet = !errPulse && !periodEnd;
  AST_RD_IDLE: assert property (!regRdStb |=> regRdData == 8'h00)
    else $error("read data not idle");
  AST_UNMAP: assert property (regRdStb && regAddr == 8'h00 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  AST_RST: assert property ($past(rst) |-> !irq && regRdData == 8'h00)
    else $error("outputs active after reset");
  AST_THR: assert property (regWrStb && regAddr == 8'hAF ##1 !regWrStb ##1
    regRdStb && regAddr == 8'hAF |=> regRdData == $past(regWrData, 3))
    else $error("threshold readback wrong");
  AST_LIVE: assert property (regRdStb && regAddr == 8'hB0 && quiet
    ##1 !regRdStb && !regWrStb && quiet ##1 regRdStb && regAddr == 8'hB0
    |=> regRdData == $past(regRdData, 2)) else $error("count moved without errors");
  AST_SNAP: assert property (regRdStb && regAddr == 8'hB4 ##1 !regRdStb
    ##1 regRdStb && regAddr == 8'hB4 |=> regRdData == $past(regRdData, 2))
    else $error("snapshot byte changed");
  AST_CLR: assert property (regWrStb && regAddr == 8'hC1 && regWrData == 8'hFF
    && quiet ##1 quiet |=> !irq) else $error("irq stays after clear");
  AST_MASK: assert property (regWrStb && regAddr == 8'hC2 && regWrData == 8'h00
    |=> ##1 !irq) else $error("irq stays while masked");
  AST_FLOAT: assert property (regRdStb && regAddr == 8'hB5
    |=> (regRdData[7:4] == 4'h0) == (regRdData[3:0] == 4'h0))
    else $error("float fields inconsistent");
endmodule
`default_nettype wire

// ==== test/tpe_error_count_tb_top.sv ====
// Self-checking bench for the error counter, random and corner cases.
// Drives every port itself; the checker is bound at the foot.
`timescale 1ns/100ps
`default_nettype none
module tpe_error_count_tb_top;
  import tpe_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic errPulse = 1'b0;
  logic periodEnd = 1'b0;
  wire logic [7:0] regRdData;
  wire logic irq;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;
  logic [39:0] cnt;
  logic [39:0] snap;
  logic [7:0] q;
  logic [7:0] t;
  always #5 ref_clk = ~ref_clk;
  tpe_error_count tpe_error_count_i (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .errPulse(errPulse), .periodEnd(periodEnd), .irq(irq));
  task report_and_stop;
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
  end
  task chk(string nm, logic [7:0] s, logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
  endtask
  task rd(logic [7:0] a);
    @(posedge ref_clk);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1 q = regRdData;
  endtask
  task settle(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task err(int k);
    repeat (k) begin
      @(posedge ref_clk);
      errPulse <= 1'b1;
    end
    @(posedge ref_clk);
    errPulse <= 1'b0;
    cnt = cnt + 40'(k);
  endtask
  task rdcnt(logic [39:0] e);
    for (int i = 0; i < 5; i++) begin
      rd(8'(TPE_OFF_COUNT0 + i));
      chk("count byte", q, e[8*i +: 8]);
    end
  endtask
  function automatic logic [7:0] fenc(logic [39:0] c);
    fenc = 8'h00;
    for (int i = 0; i < 10; i++)
      if (c[4*i +: 4] != 4'h0) fenc = {c[4*i +: 4], 4'(i + 1)};
  endfunction
  function automatic logic [39:0] dec(logic [7:0] v);
    dec = (v[3:0] == 4'h0) ? 40'h0 : 40'(v[7:4]) << (4 * (v[3:0] - 1));
  endfunction
  initial begin
    void'($urandom(18646));
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd(TPE_OFF_THRESHOLD);
    chk("threshold reset", q, TPE_RST_THRESHOLD);
    rd(TPE_OFF_MASK);
    chk("mask reset", q, 8'h00);
    rd(8'h00);
    chk("unmapped", q, TPE_RD_UNMAPPED);
    wr(TPE_OFF_COUNT0, 8'h5A);
    rdcnt(40'h0);
    for (int k = 0; k < 4; k++) begin
      t = (k == 0) ? 8'h11 : {4'($urandom_range(15, 1)), 4'($urandom_range(2))};
      wr(TPE_OFF_CONTROL, 8'h83);
      wr(TPE_OFF_STATUS, 8'hFF);
      wr(TPE_OFF_MASK, 8'h01);
      wr(TPE_OFF_THRESHOLD, t);
      rd(TPE_OFF_THRESHOLD);
      chk("threshold", q, t);
      cnt = 40'h0;
      err(int'(dec(t)));
      settle(3);
      chk("irq at target", {7'h00, irq}, 8'h00);
      err(1);
      settle(3);
      chk("irq above", {7'h00, irq}, 8'h01);
      wr(TPE_OFF_MASK, 8'h00);
      settle(2);
      chk("irq masked", {7'h00, irq}, 8'h00);
      wr(TPE_OFF_MASK, 8'h01);
      settle(2);
      chk("irq unmasked", {7'h00, irq}, 8'h01);
      wr(TPE_OFF_STATUS, 8'hFF);
      settle(2);
      chk("irq cleared", {7'h00, irq}, 8'h00);
    end
    err($urandom_range(700, 300));
    rd(TPE_OFF_FLOAT);
    chk("float", q, fenc(cnt));
    rd(TPE_OFF_COUNT0);
    chk("live low", q, cnt[7:0]);
    rd(TPE_OFF_COUNT0);
    snap = cnt;
    err(300);
    for (int i = 1; i < 5; i++) begin
      rd(8'(TPE_OFF_COUNT0 + i));
      chk("snapshot", q, snap[8*i +: 8]);
    end
    rd(TPE_OFF_COUNT4);
    chk("snapshot", q, snap[39:32]);
    rdcnt(cnt);
    t = 8'($urandom_range(2));
    wr(TPE_OFF_CONTROL, 8'h80 + t);
    rd(TPE_OFF_CONTROL);
    chk("period select", q, t);
    cnt = 40'h0;
    n = $urandom_range(600, 1);
    err(n);
    rdcnt(40'h0);
    @(posedge ref_clk);
    periodEnd <= 1'b1;
    errPulse <= 1'b1;
    @(posedge ref_clk);
    periodEnd <= 1'b0;
    errPulse <= 1'b0;
    err(5);
    rdcnt(40'(n + 1));
    rd(TPE_OFF_STATUS);
    chk("period status", q & 8'h02, 8'h02);
    report_and_stop;
  end
endmodule
bind tpe_error_count tpe_error_count_asserts tpe_error_count_asserts_i (.ref_clk(ref_clk),
  .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
  .regRdStb(regRdStb), .regRdData(regRdData), .errPulse(errPulse),
  .periodEnd(periodEnd), .irq(irq));
`default_nettype wire
